// [dv/alarm_led_status_encoder_tb.sv]
// Self-checking bench for the alarm lamp encoder
module alarm_led_status_encoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic output_enable_n = 1'h0, protocol_open = 1'h1;
  logic [1:0] addr_level_first = 2'h1, addr_level_second = 2'h2;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, q;
  wire [31:0] prdata;
  wire pready, irq, fail_oe, otw_oe, health_oe, fl, ol, hl;
  int error_cnt = 0, check_count = 0;
  logic [12:0] cv [14] = '{13'h1000, 13'h1001, 13'h1002, 13'h1004, 13'h1008, 13'h1010, 13'h1020,
    13'h1040, 13'h1080, 13'h1100, 13'h1200, 13'h1400, 13'h1800, 13'h0000};
  logic [7:0] ev [14] = '{8'h18, 8'h3A, 8'h6F, 8'h4D, 8'h4D, 8'h4D, 8'h01, 8'h01, 8'h08, 8'h5C, 8'h09,
    8'h18, 8'h18, 8'h80};
  logic [7:0] mv [14] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF7, 8'hFF, 8'hEE, 8'hFF, 8'hFF,
    8'hDF, 8'hFF, 8'h80};
  // Clock at 200 MHz
  always #2.5 pclk = ~pclk;
  alarm_led_status_encoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
    .output_enable_n(output_enable_n), .protocol_open(protocol_open), .addr_level_first(addr_level_first),
    .addr_level_second(addr_level_second), .lamp_input_ok(), .lamp_output_ok(), .lamp_service(),
    .lamp_failure(), .failure_n_o(), .failure_n_oe(fail_oe), .overheat_warning_n_o(),
    .overheat_warning_n_oe(otw_oe), .output_health_n_o(), .output_health_n_oe(health_oe),
    .insertion_indicator(), .main_output_on(), .rs485_mode(), .addr_low(), .irq(irq));
  shelf_monitor mon (.failure_n_oe(fail_oe), .overheat_warning_n_oe(otw_oe), .output_health_n_oe(health_oe),
    .failure_line(fl), .overheat_line(ol), .health_line(hl));
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One APB transfer, idle cycle after
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      final_report();
    end
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    check_count++;
    if ((g & m) !== (e & m)) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    repeat (6) @(posedge pclk);
    bus(1'h0, 12'h004, 32'h0, q);
    chk(q, 32'h1000, 32'h1FFF);
    bus(1'h0, 12'h020, 32'h0, q);
    chk(q, 32'h0, 32'hFFFFFFFF);
    bus(1'h0, 12'h010, 32'h0, q);
    chk(q, 32'h19, 32'h3F);
    bus(1'h0, 12'h000, 32'h0, q);
    chk(q, 32'h2500, 32'h3F00);
    for (int i = 0; i < 14; i++) begin
      bus(1'h1, 12'h004, {19'h0, cv[i]}, q);
      bus(1'h0, 12'h000, 32'h0, q);
      chk({21'h0, fl, ol, hl, q[7:0]}, {21'h0, ~ev[i][2:0], ev[i]}, {21'h0, mv[i][2:0], mv[i]});
    end
    $display("lamp table done");
    output_enable_n <= 1'h1;
    repeat (6) @(posedge pclk);
    bus(1'h0, 12'h000, 32'h0, q);
    chk(q, 32'h0, 32'h100);
    output_enable_n <= 1'h0;
    protocol_open <= 1'h0;
    repeat (6) @(posedge pclk);
    bus(1'h1, 12'h004, 32'h1800, q);
    bus(1'h0, 12'h000, 32'h0, q);
    chk(q, 32'h2618, 32'h3FBF);
    bus(1'h1, 12'h008, 32'hF, q);
    bus(1'h1, 12'h00C, 32'h1, q);
    bus(1'h1, 12'h004, 32'h1004, q);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1, 32'h1);
    bus(1'h1, 12'h00C, 32'h0, q);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0, 32'h1);
    bus(1'h1, 12'h004, 32'h1000, q);
    bus(1'h0, 12'h008, 32'h0, q);
    chk(q, 32'h5, 32'h5);
    bus(1'h1, 12'h008, 32'hF, q);
    bus(1'h0, 12'h008, 32'h0, q);
    chk(q, 32'h0, 32'hF);
    $display("interrupt test done");
    final_report();
  end
endmodule

// [dv/alarm_led_sva.sv]
// Port assertions for the alarm lamp encoder
module alarm_led_sva (
  input wire pclk,
  input wire presetn,
  input wire lamp_input_ok,
  input wire lamp_output_ok,
  input wire lamp_service,
  input wire lamp_failure,
  input wire failure_n_o,
  input wire failure_n_oe,
  input wire overheat_warning_n_o,
  input wire overheat_warning_n_oe,
  input wire output_health_n_o,
  input wire output_health_n_oe,
  input wire protocol_open,
  input wire [1:0] addr_level_first,
  input wire [1:0] addr_level_second,
  input wire rs485_mode,
  input wire [3:0] addr_low
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Straps held long enough to pass the synchroniser
  sequence straps_steady;
    $stable({addr_level_second, addr_level_first, protocol_open})[*4];
  endsequence
  a_fail_lamp: assert property (failure_n_oe |-> lamp_failure) else $error("fail line without lamp");
  a_otw_service: assert property (overheat_warning_n_oe |-> lamp_service) else $error("otw without lamp");
  a_shut_state: assert property (overheat_warning_n_oe && failure_n_oe |-> !lamp_output_ok && output_health_n_oe)
    else $error("shutdown state wrong");
  a_alarm_only: assert property (overheat_warning_n_oe && !failure_n_oe |-> lamp_output_ok && !output_health_n_oe)
    else $error("thermal alarm state wrong");
  a_input_dark: assert property (!lamp_input_ok |-> !lamp_output_ok && !lamp_service && !lamp_failure)
    else $error("lamps lit without input");
  a_both_lit: assert property (lamp_service && lamp_failure |-> failure_n_oe && overheat_warning_n_oe)
    else $error("service and fault lamps wrong");
  a_drain_low: assert property (!failure_n_o && !overheat_warning_n_o && !output_health_n_o)
    else $error("open drain level not low");
  a_addr_map: assert property (straps_steady |-> addr_low == {addr_level_second, addr_level_first})
    else $error("address bits wrong");
  a_mode_pick: assert property (straps_steady |-> rs485_mode == !protocol_open) else $error("mode wrong");
endmodule
bind alarm_led_status_encoder alarm_led_sva sva (.pclk(pclk), .presetn(presetn), .lamp_input_ok(lamp_input_ok),
  .lamp_output_ok(lamp_output_ok), .lamp_service(lamp_service), .lamp_failure(lamp_failure),
  .failure_n_o(failure_n_o), .failure_n_oe(failure_n_oe), .overheat_warning_n_o(overheat_warning_n_o),
  .overheat_warning_n_oe(overheat_warning_n_oe), .output_health_n_o(output_health_n_o),
  .output_health_n_oe(output_health_n_oe), .protocol_open(protocol_open), .addr_level_first(addr_level_first),
  .addr_level_second(addr_level_second), .rs485_mode(rs485_mode), .addr_low(addr_low));

// [dv/shelf_monitor.sv]
// Shelf controller side of the pulled-up alarm lines
module shelf_monitor (
  input wire failure_n_oe,
  input wire overheat_warning_n_oe,
  input wire output_health_n_oe,
  output wire failure_line,
  output wire overheat_line,
  output wire health_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-up wins unless the drain sinks the line
  assign failure_line = failure_n_oe ? 1'h0 : 1'h1;
  assign overheat_line = overheat_warning_n_oe ? 1'h0 : 1'h1;
  assign health_line = output_health_n_oe ? 1'h0 : 1'h1;
endmodule

// [rtl/alarm_led_map.vh]
// Constants for the alarm and indicator lamp encoder
`ifndef ALARM_LED_MAP_VH
`define ALARM_LED_MAP_VH
// Register byte addresses
`define REG_STATUS 12'h000
`define REG_CTRL 12'h004
`define REG_IRQ_STATUS 12'h008
`define REG_IRQ_MASK 12'h00C
`define REG_STRAPS 12'h010
// Condition bit positions in the control register
`define C_THERM_ALARM 0
`define C_THERM_SHUT 1
`define C_FUSE 2
`define C_BOOST 3
`define C_OV_LATCH 4
`define C_AC_BAD 5
`define C_AC_ABSENT 6
`define C_OVERLOAD 7
`define C_INT_FAIL 8
`define C_STANDBY 9
`define C_SERVICE 10
`define C_COMM_FAULT 11
`define C_INSERTED 12
`define NUM_COND 13
`define CTRL_RESET 13'h1000
// Blink and pulse timing
`define CLK_HZ 200000000
`define PULSE_MS 1
`define BLINK_MS 250
`define PULSE_CYC (`CLK_HZ / 1000 * `PULSE_MS)
`define BLINK_CYC (`CLK_HZ / 1000 * `BLINK_MS)
// Interrupt event bits
`define NUM_EVT 4
`define E_FAIL 0
`define E_OTW 1
`define E_HEALTH 2
`define E_STRAP 3
`endif

// [rtl/alarm_led_status_encoder.v]
// Alarm line and front-panel lamp encoder with APB register access
//
// Implementation choices: the placing of the registers and register access over APB.
`include "alarm_led_map.vh"

// Operation
// - Thermal alarm: both ok and service lamps lit, overheat warning low
// - Thermal shutdown: all three alarm lines low, service and failure lamps lit
// - Fuse, boost or over-voltage latch: failure lamp, failure and health lines low
// - Input out of limits: input lamp blinks, health line low
// - Overload: output lamp blinks, health line pulses at 1 ms
// - Non-fatal internal fault: ok lamps lit, failure lamp, failure line low
// - Bus mode service request blinks service lamp, alarms high
// - RS485 comms fault blinks failure lamp, alarms high
// - Health line low whenever main output loss is imminent
// - Main output on in analog/bus mode when enable input is low
// - Open protocol strap selects bus mode, tied strap selects RS485
// - Address bits A3..A0 formed from the two address-level straps
// - Alarm lines are active-low open-drain: pull low or release
module alarm_led_status_encoder (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire output_enable_n,
  input wire protocol_open,
  input wire [1:0] addr_level_first,
  input wire [1:0] addr_level_second,
  output reg lamp_input_ok,
  output reg lamp_output_ok,
  output reg lamp_service,
  output reg lamp_failure,
  output wire failure_n_o,
  output wire failure_n_oe,
  output wire overheat_warning_n_o,
  output wire overheat_warning_n_oe,
  output wire output_health_n_o,
  output wire output_health_n_oe,
  output reg insertion_indicator,
  output reg main_output_on,
  output reg rs485_mode,
  output reg [3:0] addr_low,
  output wire irq
);
  reg [`NUM_COND-1:0] ctrl_r;
  reg [`NUM_EVT-1:0] irq_status_r;
  reg [`NUM_EVT-1:0] irq_mask_r;
  reg [31:0] prdata_r;
  reg fail_r;
  reg otw_r;
  reg health_r;
  reg fail_nxt;
  reg otw_nxt;
  reg health_nxt;
  reg in_ok_nxt;
  reg out_ok_nxt;
  reg svc_nxt;
  reg flt_nxt;
  reg [5:0] strap_prev_r;
  wire [5:0] strap_s;
  wire blink;
  wire pulse;
  wire wr;
  wire rd;
  wire [`NUM_EVT-1:0] evt;
  wire [`NUM_EVT-1:0] w1c;

  // Pin levels pass two flip-flops before use
  pin_sync #(.W(6)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({output_enable_n, protocol_open, addr_level_second, addr_level_first}),
    .q(strap_s)
  );

  // Lamp blink rate and 1 ms health pulse
  period_tick #(.HALF(`BLINK_CYC)) u_blink (
    .pclk(pclk),
    .presetn(presetn),
    .wave(blink)
  );
  period_tick #(.HALF(`PULSE_CYC)) u_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .wave(pulse)
  );

  // APB access: zero wait states, never an error
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_r;

  // Condition decode, highest severity first
  always @* begin
    in_ok_nxt = 1'b1;
    out_ok_nxt = 1'b1;
    svc_nxt = 1'b0;
    flt_nxt = 1'b0;
    fail_nxt = 1'b0;
    otw_nxt = 1'b0;
    health_nxt = 1'b0;
    if (ctrl_r[`C_AC_ABSENT]) begin
      in_ok_nxt = 1'b0;
      out_ok_nxt = 1'b0;
      health_nxt = 1'b1;
    end else if (ctrl_r[`C_THERM_SHUT]) begin
      out_ok_nxt = 1'b0;
      svc_nxt = 1'b1;
      flt_nxt = 1'b1;
      fail_nxt = 1'b1;
      otw_nxt = 1'b1;
      health_nxt = 1'b1;
    end else if (ctrl_r[`C_FUSE] | ctrl_r[`C_BOOST] | ctrl_r[`C_OV_LATCH]) begin
      out_ok_nxt = 1'b0;
      flt_nxt = 1'b1;
      fail_nxt = 1'b1;
      health_nxt = 1'b1;
    end else if (ctrl_r[`C_AC_BAD]) begin
      in_ok_nxt = blink;
      out_ok_nxt = 1'b0;
      health_nxt = 1'b1;
    end else if (ctrl_r[`C_STANDBY]) begin
      out_ok_nxt = 1'b0;
      health_nxt = 1'b1;
    end else if (ctrl_r[`C_THERM_ALARM]) begin
      svc_nxt = 1'b1;
      otw_nxt = 1'b1;
    end else if (ctrl_r[`C_OVERLOAD]) begin
      out_ok_nxt = blink;
      health_nxt = pulse;
    end else if (ctrl_r[`C_INT_FAIL]) begin
      flt_nxt = 1'b1;
      fail_nxt = 1'b1;
    end else if (ctrl_r[`C_SERVICE] & ~rs485_mode) begin
      svc_nxt = blink;
    end else if (ctrl_r[`C_COMM_FAULT] & rs485_mode) begin
      flt_nxt = blink;
    end
  end

  // Registered lamps, alarms and strap decode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_input_ok <= 1'b0;
      lamp_output_ok <= 1'b0;
      lamp_service <= 1'b0;
      lamp_failure <= 1'b0;
      fail_r <= 1'b0;
      otw_r <= 1'b0;
      health_r <= 1'b0;
      insertion_indicator <= 1'b1;
      main_output_on <= 1'b0;
      rs485_mode <= 1'b0;
      addr_low <= 4'h0;
    end else begin
      lamp_input_ok <= in_ok_nxt;
      lamp_output_ok <= out_ok_nxt;
      lamp_service <= svc_nxt;
      lamp_failure <= flt_nxt;
      fail_r <= fail_nxt;
      otw_r <= otw_nxt;
      health_r <= health_nxt;
      insertion_indicator <= ~ctrl_r[`C_INSERTED];
      rs485_mode <= ~strap_s[4];
      main_output_on <= ~strap_s[5] & ~rs485_mode;
      addr_low <= {strap_s[3:2], strap_s[1:0]};
    end
  end

  // Open-drain drive: output low, enable only while asserting
  assign failure_n_o = 1'b0;
  assign failure_n_oe = fail_r;
  assign overheat_warning_n_o = 1'b0;
  assign overheat_warning_n_oe = otw_r;
  assign output_health_n_o = 1'b0;
  assign output_health_n_oe = health_r;

  // Interrupt events: alarm assertions and strap changes
  assign evt[`E_FAIL] = fail_nxt & ~fail_r;
  assign evt[`E_OTW] = otw_nxt & ~otw_r;
  assign evt[`E_HEALTH] = health_nxt & ~health_r;
  assign evt[`E_STRAP] = strap_s != strap_prev_r;
  assign w1c = (wr && paddr == `REG_IRQ_STATUS) ? pwdata[`NUM_EVT-1:0] : {`NUM_EVT{1'b0}};
  assign irq = |(irq_status_r & irq_mask_r);

  // Register writes; a new event wins over a clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RESET;
      irq_status_r <= {`NUM_EVT{1'b0}};
      irq_mask_r <= {`NUM_EVT{1'b0}};
      strap_prev_r <= 6'h00;
    end else begin
      strap_prev_r <= strap_s;
      irq_status_r <= (irq_status_r & ~w1c) | evt;
      if (wr && paddr == `REG_CTRL) begin
        ctrl_r <= pwdata[`NUM_COND-1:0];
      end else if (wr && paddr == `REG_IRQ_MASK) begin
        irq_mask_r <= pwdata[`NUM_EVT-1:0];
      end
    end
  end

  // Read data captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (rd && !penable) begin
      if (paddr == `REG_STATUS) begin
        prdata_r <= {18'h00000, addr_low, rs485_mode, main_output_on, insertion_indicator,
                     lamp_failure, lamp_service, lamp_output_ok, lamp_input_ok, fail_r, otw_r, health_r};
      end else if (paddr == `REG_CTRL) begin
        prdata_r <= {19'h00000, ctrl_r};
      end else if (paddr == `REG_IRQ_STATUS) begin
        prdata_r <= {28'h0000000, irq_status_r};
      end else if (paddr == `REG_IRQ_MASK) begin
        prdata_r <= {28'h0000000, irq_mask_r};
      end else if (paddr == `REG_STRAPS) begin
        prdata_r <= {26'h0000000, strap_s};
      end else begin
        prdata_r <= 32'h00000000;
      end
    end
  end
endmodule

// [rtl/period_tick.v]
// Free-running divider giving a square wave of a given half period
module period_tick #(
  parameter HALF = 200000
) (
  input wire pclk,
  input wire presetn,
  output wire wave
);
  reg [27:0] cnt_r;
  reg wave_r;

  // Toggle the wave every HALF cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 28'h0000000;
      wave_r <= 1'b0;
    end else if (cnt_r == HALF - 1) begin
      cnt_r <= 28'h0000000;
      wave_r <= ~wave_r;
    end else begin
      cnt_r <= cnt_r + 28'h0000001;
    end
  end

  assign wave = wave_r;
endmodule

// [rtl/pin_sync.v]
// Two-flop synchroniser for a vector of asynchronous pin levels
module pin_sync #(
  parameter W = 4
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // First stage feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule
